// *** core/link_policy_pkg.sv ***
package link_policy_pkg;

  localparam int          NUM_LANES       = 2;
  localparam int          CLK_MHZ         = 250;
  localparam int          CYCLES_PER_MS   = CLK_MHZ * 1000;

  localparam logic [7:0]  OFS_POLICY_CTRL = 8'h22;
  localparam logic [7:0]  OFS_LANE1_STAT  = 8'h24;
  localparam logic [7:0]  OFS_LANE2_STAT  = 8'h25;
  localparam logic [7:0]  RST_POLICY_CTRL = 8'h04;

  // Control field positions
  localparam int          BIT_START_TERM_OFF   = 7;
  localparam int          BIT_LP_INTERVAL_HI   = 6;
  localparam int          BIT_LP_INTERVAL_LO   = 5;
  localparam int          BIT_LP_DETECT_DIS    = 4;
  localparam int          BIT_DS_INTERVAL_HI   = 3;
  localparam int          BIT_DS_INTERVAL_LO   = 2;
  localparam int          BIT_WARM_RESET_SKIP  = 1;
  localparam int          BIT_COMPLIANCE_DIS   = 0;

  // Status field positions
  localparam int          BIT_LONG_CHANNEL     = 7;
  localparam int          BIT_DUAL_LANE        = 4;
  localparam int          BIT_COMPLIANCE       = 3;
  localparam int          BIT_ACTIVE_STATE     = 2;
  localparam int          BIT_LOWPOWER         = 1;
  localparam int          BIT_DISCONNECTED     = 0;

  // Detect intervals in milliseconds
  localparam logic [7:0]  LP_MS_0 = 8'h30;  // 48
  localparam logic [7:0]  LP_MS_1 = 8'h54;  // 84
  localparam logic [7:0]  LP_MS_2 = 8'h78;  // 120
  localparam logic [7:0]  LP_MS_3 = 8'h9c;  // 156
  localparam logic [7:0]  DS_MS_0 = 8'h04;  // 4
  localparam logic [7:0]  DS_MS_1 = 8'h06;  // 6
  localparam logic [7:0]  DS_MS_2 = 8'h24;  // 36
  localparam logic [7:0]  DS_MS_3 = 8'h54;  // 84

  typedef enum logic [2:0] {
    LS_DISCONNECT = 3'b000,
    LS_RXDETECT   = 3'b001,
    LS_POLLING    = 3'b010,
    LS_U0         = 3'b011,
    LS_U1         = 3'b100,
    LS_U2U3       = 3'b101,
    LS_COMPLIANCE = 3'b110,
    LS_INACTIVE   = 3'b111
  } link_state_e;

  typedef struct packed {
    link_state_e state;
    logic        after_warm_reset;
    logic        polled_in_warm_reset;
    logic        dual_lane;
    logic        long_channel;
    logic [3:0]  long_channel_eq;
    logic [3:0]  short_channel_eq;
  } lane_link_s;

  typedef struct packed {
    logic        detect_strobe;
    logic        termination_off;
    logic        compliance_allowed;
    logic [3:0]  applied_eq;
  } lane_ctl_s;

endpackage

// *** core/usb_link_rxdet_policy_status.sv ***
// Notes on behaviour
// - Termination turns off at warm-reset detect start and Inactive entry only when the start bit is 1.
// - In U2/U3 detection repeats every 48, 84, 120 or 156 ms per the low-power interval field.
// - The low-power detect disable bit at 1 stops all detection in U2/U3.
// - With the skip bit set, polling seen during warm reset suppresses the following detection.
// - The compliance bit at 1 forbids compliance mode, at 0 the link machine decides.
// - Status bit 7 shows long-channel use in fast equalization and 0 when equalization is off.
// - Status bit 4 is 1 in dual-lane operation and 0 in single-lane.
// - Status bit 3 is 1 only while in compliance mode.
// - Status bit 2 sets on entry to U0.
// - Status bit 1 sets on entry to U2 or U3.
// - Status bit 0 sets on entry to Disconnect and is 1 after reset.
// - Fast mode means equalization enabled with the mode low bit at 0.
// - Fast mode applies the long-channel code on a long channel, else the short-channel code.
`timescale 1ns/100ps
`default_nettype none

module usb_link_rxdet_policy_status #(
  parameter int MS_CYCLES = link_policy_pkg::CYCLES_PER_MS
) (
  input  wire logic                       core_clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic [7:0]                 reg_addr_in,
  input  wire logic                       reg_wr_in,
  input  wire logic [7:0]                 reg_wdata_in,
  input  wire logic                       reg_rd_in,
  input  wire logic                       adaptive_eq_enable_in,
  input  wire logic [1:0]                 adaptive_eq_mode_in,
  input  wire link_policy_pkg::lane_link_s [1:0] lane_link_in,
  output logic [7:0]                      reg_rdata_out,
  output link_policy_pkg::lane_ctl_s [1:0] lane_ctl_out
);

  localparam int PW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

  logic [7:0]  ctrl_ff;
  logic [7:0]  status_w [2];
  logic        fast_aeq;

  function automatic logic [7:0] interval_ms(input logic lowpower, input logic [1:0] code);
    case ({lowpower, code})
      3'b100:  interval_ms = link_policy_pkg::LP_MS_0;
      3'b101:  interval_ms = link_policy_pkg::LP_MS_1;
      3'b110:  interval_ms = link_policy_pkg::LP_MS_2;
      3'b111:  interval_ms = link_policy_pkg::LP_MS_3;
      3'b000:  interval_ms = link_policy_pkg::DS_MS_0;
      3'b001:  interval_ms = link_policy_pkg::DS_MS_1;
      3'b010:  interval_ms = link_policy_pkg::DS_MS_2;
      default: interval_ms = link_policy_pkg::DS_MS_3;
    endcase
  endfunction

  assign fast_aeq = adaptive_eq_enable_in & ~adaptive_eq_mode_in[0];

  // Control byte is the only writable register
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      ctrl_ff <= link_policy_pkg::RST_POLICY_CTRL;
    else if (reg_wr_in && reg_addr_in == link_policy_pkg::OFS_POLICY_CTRL)
      ctrl_ff <= reg_wdata_in;
  end

  // Status writes are ignored; the reserved status bits 6 and 5 always read 0
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        link_policy_pkg::OFS_POLICY_CTRL: reg_rdata_out <= ctrl_ff;
        link_policy_pkg::OFS_LANE1_STAT:  reg_rdata_out <= status_w[0];
        link_policy_pkg::OFS_LANE2_STAT:  reg_rdata_out <= status_w[1];
        default:                          reg_rdata_out <= 8'h00;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < link_policy_pkg::NUM_LANES; g++)
    begin : g_lane
      link_policy_pkg::lane_link_s  lk;
      link_policy_pkg::link_state_e prev_state_ff;
      logic              u0_flag_ff;
      logic              lowpower_flag_ff;
      logic              disc_flag_ff;
      logic              skip_ff;
      logic [PW-1:0]     prescale_ff;
      logic [7:0]        ms_count_ff;
      logic              in_lp;
      logic              timer_run;
      logic              ms_tick;
      logic [7:0]        limit_ms;

      assign lk       = lane_link_in[g];
      assign in_lp    = (lk.state == link_policy_pkg::LS_U2U3);
      // Code is read live, so a rewrite stretches or shortens the running count
      assign limit_ms = in_lp
        ? interval_ms(1'b1, ctrl_ff[link_policy_pkg::BIT_LP_INTERVAL_HI:
                                    link_policy_pkg::BIT_LP_INTERVAL_LO])
        : interval_ms(1'b0, ctrl_ff[link_policy_pkg::BIT_DS_INTERVAL_HI:
                                    link_policy_pkg::BIT_DS_INTERVAL_LO]);
      assign timer_run = in_lp
        ? ~ctrl_ff[link_policy_pkg::BIT_LP_DETECT_DIS]
        : (lk.state == link_policy_pkg::LS_RXDETECT) & ~skip_ff;
      assign ms_tick = (prescale_ff == PW'(MS_CYCLES - 1));

      // Skip holds until the link reaches a settled state again
      always_ff @(posedge core_clk_in)
      begin
        if (sys_rst_in)
          skip_ff <= 1'b0;
        else if (ctrl_ff[link_policy_pkg::BIT_WARM_RESET_SKIP] && lk.polled_in_warm_reset)
          skip_ff <= 1'b1;
        else if (lk.state == link_policy_pkg::LS_U0 || lk.state == link_policy_pkg::LS_DISCONNECT)
          skip_ff <= 1'b0;
      end

      // Timer restarts whenever detection is not due, so a new interval starts fresh
      always_ff @(posedge core_clk_in)
      begin
        if (sys_rst_in || !timer_run)
        begin
          prescale_ff <= '0;
          ms_count_ff <= 8'h00;
        end
        else if (ms_tick)
        begin
          prescale_ff <= '0;
          ms_count_ff <= (ms_count_ff == limit_ms - 8'h01) ? 8'h00 : ms_count_ff + 8'h01;
        end
        else
          prescale_ff <= prescale_ff + PW'(1);
      end

      // Registered so the strobe leaves straight from a flop
      always_ff @(posedge core_clk_in)
      begin
        if (sys_rst_in)
          lane_ctl_out[g].detect_strobe <= 1'b0;
        else
          lane_ctl_out[g].detect_strobe <= timer_run & ms_tick
                                         & (ms_count_ff == limit_ms - 8'h01);
      end

      // Dropping termination avoids a detect race with the far end
      always_ff @(posedge core_clk_in)
      begin
        if (sys_rst_in)
          lane_ctl_out[g].termination_off <= 1'b0;
        else
          lane_ctl_out[g].termination_off <= ctrl_ff[link_policy_pkg::BIT_START_TERM_OFF]
            & ((lk.state == link_policy_pkg::LS_INACTIVE)
               | (lk.after_warm_reset & lk.state == link_policy_pkg::LS_RXDETECT));
      end

      // Permission follows the control bit one cycle late
      always_ff @(posedge core_clk_in)
      begin
        if (sys_rst_in)
          lane_ctl_out[g].compliance_allowed <= 1'b1;
        else
          lane_ctl_out[g].compliance_allowed <=
            ~ctrl_ff[link_policy_pkg::BIT_COMPLIANCE_DIS];
      end

      // Outside fast mode the short-channel code doubles as the fixed setting
      always_ff @(posedge core_clk_in)
      begin
        if (sys_rst_in)
          lane_ctl_out[g].applied_eq <= 4'h0;
        else if (fast_aeq && lk.long_channel)
          lane_ctl_out[g].applied_eq <= lk.long_channel_eq;
        else
          lane_ctl_out[g].applied_eq <= lk.short_channel_eq;
      end

      // Flags follow entries only; other states leave the last entry shown
      always_ff @(posedge core_clk_in)
      begin
        if (sys_rst_in)
        begin
          prev_state_ff    <= link_policy_pkg::LS_DISCONNECT;
          u0_flag_ff       <= 1'b0;
          lowpower_flag_ff <= 1'b0;
          disc_flag_ff     <= 1'b1;
        end
        else
        begin
          prev_state_ff <= lk.state;
          if (lk.state != prev_state_ff && (lk.state == link_policy_pkg::LS_U0
              || in_lp || lk.state == link_policy_pkg::LS_DISCONNECT))
          begin
            u0_flag_ff       <= (lk.state == link_policy_pkg::LS_U0);
            lowpower_flag_ff <= in_lp;
            disc_flag_ff     <= (lk.state == link_policy_pkg::LS_DISCONNECT);
          end
        end
      end

      // Live bits track inputs; state flags come from flops
      always_comb
      begin
        status_w[g] = 8'h00;
        status_w[g][link_policy_pkg::BIT_LONG_CHANNEL] = fast_aeq & lk.long_channel;
        status_w[g][link_policy_pkg::BIT_DUAL_LANE]    = lk.dual_lane;
        status_w[g][link_policy_pkg::BIT_COMPLIANCE]   =
          (lk.state == link_policy_pkg::LS_COMPLIANCE)
          & ~ctrl_ff[link_policy_pkg::BIT_COMPLIANCE_DIS];
        status_w[g][link_policy_pkg::BIT_ACTIVE_STATE] = u0_flag_ff;
        status_w[g][link_policy_pkg::BIT_LOWPOWER]     = lowpower_flag_ff;
        status_w[g][link_policy_pkg::BIT_DISCONNECTED] = disc_flag_ff;
      end
    end
  endgenerate

endmodule // usb_link_rxdet_policy_status

`default_nettype wire

// *** testbench/link_partner_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module link_partner_model (
  input  wire logic                              clk_in,
  input  wire logic                              rst_in,
  input  wire link_policy_pkg::lane_link_s [1:0] req_in,
  input  wire logic [3:0]                        lag_in,
  output var  link_policy_pkg::lane_link_s [1:0] link_out
);
  logic [3:0] wait_ff;

  // A slow partner lands a new state only after lag_in cycles
  always_ff @(posedge clk_in)
    wait_ff <= (rst_in || req_in == link_out) ? 4'h0 : wait_ff + 4'h1;

  always_ff @(posedge clk_in)
    link_out <= rst_in ? '0 : ((wait_ff >= lag_in) ? req_in : link_out);
endmodule // link_partner_model

`default_nettype wire

// *** testbench/link_policy_properties.sv ***
`timescale 1ns/100ps
`default_nettype none

module link_policy_properties (
  input wire logic                              core_clk_in,
  input wire logic                              sys_rst_in,
  input wire logic [7:0]                        reg_addr_in,
  input wire logic                              reg_wr_in,
  input wire logic [7:0]                        reg_wdata_in,
  input wire logic                              reg_rd_in,
  input wire logic                              adaptive_eq_enable_in,
  input wire logic [1:0]                        adaptive_eq_mode_in,
  input wire link_policy_pkg::lane_link_s [1:0] lane_link_in,
  input wire logic [7:0]                        reg_rdata_out,
  input wire link_policy_pkg::lane_ctl_s [1:0]  lane_ctl_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [7:0]                   ctl_ff;
  logic [2:0]                   flg;
  logic                         fast;
  link_policy_pkg::link_state_e st;
  assign st = lane_link_in[0].state;
  assign fast = adaptive_eq_enable_in & ~adaptive_eq_mode_in[0];
  assign flg = {st == link_policy_pkg::LS_U0, st == link_policy_pkg::LS_U2U3,
                st == link_policy_pkg::LS_DISCONNECT};
  // Shadow of the control byte, status offsets take no writes
  always_ff @(posedge core_clk_in)
    ctl_ff <= sys_rst_in ? 8'h04 : ((reg_wr_in && reg_addr_in == 8'h22) ? reg_wdata_in : ctl_ff);
  sequence quiet8;
    !lane_ctl_out[0].detect_strobe [*8];
  endsequence
  chk_term_off: assert property (lane_ctl_out[0].termination_off == $past(ctl_ff[7] &&
    (st == link_policy_pkg::LS_INACTIVE || st == link_policy_pkg::LS_RXDETECT
    && lane_link_in[0].after_warm_reset))) else $error("termination mismatch");
  chk_comp_allow: assert property (lane_ctl_out[0].compliance_allowed == $past(!ctl_ff[0]))
    else $error("compliance enable mismatch");
  chk_eq_select: assert property (!$past(sys_rst_in) |-> lane_ctl_out[1].applied_eq ==
    $past((fast && lane_link_in[1].long_channel) ? lane_link_in[1].long_channel_eq
    : lane_link_in[1].short_channel_eq)) else $error("applied eq mismatch");
  chk_strobe_gap: assert property (lane_ctl_out[0].detect_strobe |=> quiet8)
    else $error("detect strobes too close");
  chk_ctrl_read: assert property (reg_rd_in && reg_addr_in == 8'h22 |=>
    reg_rdata_out == $past(ctl_ff)) else $error("control readback mismatch");
  chk_live_status: assert property (reg_rd_in && reg_addr_in == 8'h24 |=>
    reg_rdata_out[7:3] == $past({fast && lane_link_in[0].long_channel, 2'b00,
    lane_link_in[0].dual_lane, st == link_policy_pkg::LS_COMPLIANCE && !ctl_ff[0]}))
    else $error("live status mismatch");
  chk_flag_onehot: assert property (reg_rd_in && reg_addr_in == 8'h24 &&
    $past(st, 2) == $past(st) && $past(flg) != 3'b000 |=> reg_rdata_out[2:0] == $past(flg, 2))
    else $error("state flags mismatch");
  chk_read_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without read");
endmodule // link_policy_properties

bind usb_link_rxdet_policy_status link_policy_properties chk (.core_clk_in, .sys_rst_in,
  .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in, .adaptive_eq_enable_in,
  .adaptive_eq_mode_in, .lane_link_in, .reg_rdata_out, .lane_ctl_out);

`default_nettype wire

// *** testbench/usb_link_rxdet_policy_status_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module usb_link_rxdet_policy_status_tb_top;
  localparam int MS = 4;
  logic                              clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, eq_en = 1'b0;
  logic [7:0]                        addr = 8'h00, wdata = 8'h00, rdata, ctl_m = 8'h04;
  logic [1:0]                        eq_mode = 2'b00;
  logic [3:0]                        lag = 4'h0;
  logic [2:0]                        flg [2] = '{3'b001, 3'b001};
  logic [31:0]                       rng = 32'h5f23;
  logic [7:0]                        nrm [4] = '{8'h04, 8'h06, 8'h24, 8'h54};
  logic [7:0]                        lowp [4] = '{8'h30, 8'h54, 8'h78, 8'h9c};
  link_policy_pkg::lane_link_s [1:0] req = '0, link;
  link_policy_pkg::lane_ctl_s [1:0]  ctl;
  int                                n_fail = 0, n_checks = 0, cyc = 0;

  always #2 clk = ~clk;

  usb_link_rxdet_policy_status #(.MS_CYCLES(MS)) DUT (.core_clk_in(clk), .sys_rst_in(rst),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
    .adaptive_eq_enable_in(eq_en), .adaptive_eq_mode_in(eq_mode), .lane_link_in(link),
    .reg_rdata_out(rdata), .lane_ctl_out(ctl));
  link_partner_model PEER (.clk_in(clk), .rst_in(rst), .req_in(req), .lag_in(lag),
    .link_out(link));

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [7:0] stat_exp(input link_policy_pkg::lane_link_s l,
                                          input logic [2:0] f);
    return {eq_en & ~eq_mode[0] & l.long_channel, 2'b00, l.dual_lane,
            l.state == link_policy_pkg::LS_COMPLIANCE & ~ctl_m[0], f};
  endfunction

  function automatic logic [5:0] port_exp(input link_policy_pkg::lane_link_s l);
    return {ctl_m[7] & (l.state == link_policy_pkg::LS_INACTIVE
            | l.state == link_policy_pkg::LS_RXDETECT & l.after_warm_reset), ~ctl_m[0],
            (eq_en & ~eq_mode[0] & l.long_channel) ? l.long_channel_eq : l.short_channel_eq};
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    if (a == 8'h22)
      ctl_m = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    cmp(16'(rdata), 16'(e));
  endtask

  // Both lanes enter one state with the given warm-reset poll flag; other lane fields stay random
  task automatic go(input link_policy_pkg::link_state_e s, input logic p);
    logic [2:0] f;
    @(negedge clk);
    req = 30'(rnd());
    eq_en = 1'(rnd());
    eq_mode = 2'(rnd());
    lag = 4'(rnd() % 8);
    f = {s == link_policy_pkg::LS_U0, s == link_policy_pkg::LS_U2U3,
         s == link_policy_pkg::LS_DISCONNECT};
    for (int k = 0; k < 2; k++)
    begin
      req[k].state = s;
      req[k].polled_in_warm_reset = p;
      if (f != 3'b000)
        flg[k] = f;
    end
    for (int i = 0; i < 20 && link !== req; i++)
      @(negedge clk);
    repeat (2) @(negedge clk);
  endtask

  // Cycles between two strobes, 0 when none shows up
  task automatic gap(input logic [15:0] exp);
    logic [15:0] n;
    n = 16'h0000;
    for (int i = 0; i < 700 && ctl[0].detect_strobe !== 1'b1; i++)
      @(negedge clk);
    cmp(16'(ctl[1].detect_strobe), 16'(ctl[0].detect_strobe));
    while (ctl[0].detect_strobe === 1'b1 || (n != 16'h0000 && n < 16'h02bc))
    begin
      @(negedge clk);
      n++;
      if (ctl[0].detect_strobe === 1'b1)
        break;
    end
    cmp(n, exp);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_fail++;
      end_sim();
    end
  end

  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rchk(8'h22, 8'h04);
    rchk(8'h24, 8'h01);
    rchk(8'h23, 8'h00);
    wreg(8'h25, 8'hff);
    rchk(8'h25, 8'h01);
    $display("test reset values done");
    for (int c = 0; c < 4; c++)
    begin
      wreg(8'h22, {1'b0, 2'(c), 1'b0, 2'(c), 2'b00});
      go(link_policy_pkg::LS_RXDETECT, 1'b1);
      gap(16'(nrm[c] * MS));
      go(link_policy_pkg::LS_U2U3, 1'b0);
      gap(16'(lowp[c] * MS));
      go(link_policy_pkg::LS_U0, 1'b0);
    end
    wreg(8'h22, 8'h12);
    go(link_policy_pkg::LS_U2U3, 1'b0);
    gap(16'h0000);
    go(link_policy_pkg::LS_RXDETECT, 1'b1);
    gap(16'h0000);
    $display("test detect timers done");
    repeat (60)
    begin
      wreg(8'h22, 8'(rnd()));
      go(link_policy_pkg::link_state_e'(3'(rnd())), 1'(rnd()));
      for (int k = 0; k < 2; k++)
      begin
        rchk(8'h24 + 8'(k), stat_exp(req[k], flg[k]));
        cmp(16'({ctl[k].termination_off, ctl[k].compliance_allowed,
                 ctl[k].applied_eq}), 16'(port_exp(req[k])));
      end
    end
    $display("test random status done");
    @(negedge clk);
    rst = 1'b1;
    req = '0;
    ctl_m = 8'h04;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rchk(8'h22, 8'h04);
    rchk(8'h25, 8'h01);
    $display("test second reset done");
    end_sim();
  end
endmodule // usb_link_rxdet_policy_status_tb_top

`default_nettype wire
